/* bench/tb_top.sv */
// self-checking bench of the timer channel control block
`timescale 1ns/1ps
module tb_top;
   import tcc_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, seed;
   logic [3:0] pstrb;
   logic [15:0] counter_value;
   logic count_down, update_event, trigger_edge, internal_trigger_input;
   logic ch2_in, ch3_in, ch2_output, ch2_output_en, e1;
   logic [1:0] capture_event;
   logic [32:0] exp_q[$];
   logic [32:0] ev;
   int bad_count = 0;
   int n_tests = 0;
   int cap2 = 0;
   int cap3 = 0;
   int b;
   int fc[3] = '{3, 1, 10};
   int sh[3] = '{4, 1, 40};
   int lg[3] = '{12, 4, 120};
   tcc_ctl tcc_ctl_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .counter_value(counter_value),
      .count_down(count_down), .update_event(update_event), .trigger_edge(trigger_edge),
      .internal_trigger_input(internal_trigger_input), .ch2_in(ch2_in), .ch3_in(ch3_in),
      .ch2_output(ch2_output), .ch2_output_en(ch2_output_en), .capture_event(capture_event));
   tcc_far_model tcc_far_model_inst (.counter_value(counter_value), .count_down(count_down),
      .update_event(update_event), .trigger_edge(trigger_edge),
      .internal_trigger_input(internal_trigger_input), .ch2_in(ch2_in), .ch3_in(ch3_in),
      .pclk(pclk));
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   ////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [31:0] md(input logic [2:0] c, input logic sen, input logic fen);
      return {25'h0, c, sen, fen, 2'b00};
   endfunction : md
   task automatic final_report();
      $display("bad_count=%0d n_tests=%0d", bad_count, n_tests);
      if (bad_count == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : final_report
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
      end
   endtask : chk
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                      input logic [3:0] s);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      // zero-wait slave today, but no latency is assumed
      while (pready !== 1'b1 && n < 16) begin
         n++;
         @(posedge pclk);
      end
      if (n >= 16) begin
         bad_count++;
         final_report();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(a, 1'b1, d, 4'hF);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic err);
      exp_q.push_back({err, d});
      apb(a, 1'b0, 32'h0, 4'h0);
   endtask : rd
   // output settles one or two edges after its cause; outx waits four edges
   task automatic outx(input logic e);
      repeat (4) @(posedge pclk);
      chk("ch2_output", {31'h0, e}, {31'h0, ch2_output});
   endtask : outx
   task automatic pin(input int src, input int n);
      tcc_far_model_inst.hold(src, 1'b1, n);
      tcc_far_model_inst.hold(src, 1'b0, n);
   endtask : pin
   task automatic setin(input logic [7:0] m, input logic [31:0] en);
      wr(OFS_CHEN, 32'h0);
      wr(OFS_MODE, {24'h0, m});
      wr(OFS_CHEN, en);
      b = cap2;
   endtask : setin
   ////////////////////////////////////////////////////////////
   // read results leave in request order, so a plain queue pairs them
   always @(posedge pclk) begin
      if (capture_event[0] === 1'b1) begin
         cap2 <= cap2 + 1;
      end
      if (capture_event[1] === 1'b1) begin
         cap3 <= cap3 + 1;
      end
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
         ev = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h1DEADBEEF;
         chk("prdata", ev[31:0], prdata);
         chk("pslverr", {31'h0, ev[32]}, {31'h0, pslverr});
      end
   end
   initial begin
      repeat (100000) @(posedge pclk);
      bad_count++;
      final_report();
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      seed = 32'h551AD88E;
      presetn = 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(OFS_CHEN, 32'h0, 1'b0);
      rd(OFS_MODE, 32'h0, 1'b0);
      wr(OFS_CHEN, 32'hFFFFFFFF);
      rd(OFS_CHEN, 32'h3333, 1'b0);
      apb(OFS_CHEN, 1'b1, 32'h0, 4'h1);
      rd(OFS_CHEN, 32'h3300, 1'b0);
      apb(OFS_CHEN, 1'b1, 32'h0, 4'h3);
      rd(OFS_CHEN, 32'h0, 1'b0);
      rd(12'h030, 32'h0, 1'b1);
      wr(OFS_CV2, 32'd100);
      wr(OFS_CHEN, 32'h100);
      for (int m = 0; m < 2; m++) begin
         for (int d = 0; d < 2; d++) begin
            for (int c = 99; c < 102; c++) begin
               wr(OFS_MODE, 32'h0);
               tcc_far_model_inst.cnt(16'(c), 1'(d));
               wr(OFS_MODE, md((m == 1) ? CMP_PWM1 : CMP_PWM0, 1'b1, 1'b0));
               e1 = (m == 1) ? ((d == 1) ? (c > 100) : (c >= 100))
                             : ((d == 1) ? (c <= 100) : (c < 100));
               outx(e1);
            end
         end
      end
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         tcc_far_model_inst.cnt(seed[15:0], 1'b0);
         e1 = (seed[15:0] >= 16'd100);
         outx(e1);
      end
      wr(OFS_CHEN, 32'h300);
      outx(~e1);
      wr(OFS_CHEN, 32'h200);
      outx(1'b1);
      chk("ch2_output_en", 32'h0, {31'h0, ch2_output_en});
      wr(OFS_CHEN, 32'h100);
      @(posedge pclk);
      chk("ch2_output_en", 32'h1, {31'h0, ch2_output_en});
      tcc_far_model_inst.cnt(16'd150, 1'b0);
      wr(OFS_MODE, md(CMP_TIMING, 1'b1, 1'b0));
      wr(OFS_MODE, md(CMP_PWM1, 1'b1, 1'b0));
      wr(OFS_CV2, 32'd200);
      outx(1'b1);
      tcc_far_model_inst.pulse(0);
      outx(1'b0);
      tcc_far_model_inst.pulse(1);
      outx(1'b0);
      wr(OFS_MODE, md(CMP_PWM1, 1'b1, 1'b1));
      tcc_far_model_inst.pulse(1);
      outx(1'b1);
      wr(OFS_PROTECTION_LEVEL, 32'h3);
      wr(OFS_MODE, md(CMP_PWM0, 1'b0, 1'b0) | 32'h1);
      rd(OFS_MODE, md(CMP_PWM1, 1'b1, 1'b0), 1'b0);
      rd(OFS_PROTECTION_LEVEL, 32'h103, 1'b0);
      wr(OFS_PROTECTION_LEVEL, 32'h0);
      wr(OFS_MODE, md(CMP_LOW, 1'b1, 1'b0));
      outx(1'b0);
      wr(OFS_MODE, md(CMP_SET, 1'b1, 1'b0));
      outx(1'b0);
      tcc_far_model_inst.cnt(16'd200, 1'b0);
      outx(1'b1);
      wr(OFS_MODE, md(CMP_CLR, 1'b1, 1'b0));
      outx(1'b0);
      wr(OFS_MODE, md(CMP_HIGH, 1'b1, 1'b0));
      tcc_far_model_inst.cnt(16'd150, 1'b0);
      wr(OFS_MODE, md(CMP_TOGGLE, 1'b1, 1'b0));
      outx(1'b1);
      tcc_far_model_inst.cnt(16'd200, 1'b0);
      tcc_far_model_inst.cnt(16'd150, 1'b0);
      outx(1'b0);
      tcc_far_model_inst.cnt(16'h1234, 1'b0);
      for (int s = 1; s < 4; s++) begin
         setin(8'(s), 32'h100);
         pin(s - 1, 6);
         pin(s - 1, 6);
         chk("captures", 2, cap2 - b);
         chk("ch2_output_en", 32'h0, {31'h0, ch2_output_en});
      end
      rd(OFS_CV2, 32'h1234, 1'b0);
      for (int p = 0; p < 4; p++) begin
         setin({4'h0, 2'(p), 2'b01}, 32'h100);
         repeat (8) pin(0, 6);
         chk("captures", 8 >> p, cap2 - b);
      end
      b = cap2;
      repeat (4) pin(0, 6);
      wr(OFS_CHEN, 32'h0);
      wr(OFS_CHEN, 32'h100);
      repeat (4) pin(0, 6);
      chk("captures", 0, cap2 - b);
      repeat (4) pin(0, 6);
      chk("captures", 1, cap2 - b);
      setin(8'h01, 32'h300);
      tcc_far_model_inst.hold(0, 1'b1, 10);
      chk("captures", 0, cap2 - b);
      tcc_far_model_inst.hold(0, 1'b0, 10);
      chk("captures", 1, cap2 - b);
      setin(8'h01, 32'h200);
      repeat (2) pin(0, 6);
      chk("captures", 0, cap2 - b);
      for (int f = 0; f < 3; f++) begin
         setin({4'(fc[f]), 4'h1}, 32'h100);
         tcc_far_model_inst.hold(0, 1'b1, sh[f]);
         tcc_far_model_inst.hold(0, 1'b0, lg[f]);
         chk("captures", 0, cap2 - b);
         pin(0, lg[f]);
         chk("captures", 1, cap2 - b);
      end
      wr(OFS_CHEN, 32'h0);
      wr(OFS_MODE, 32'h0100);
      wr(OFS_CHEN, 32'h1000);
      b = cap3;
      repeat (2) pin(1, 6);
      chk("ch3_captures", 2, cap3 - b);
      rd(OFS_CV3, 32'h1234, 1'b0);
      final_report();
   end
endmodule : tb_top

/* bench/tcc_far_model.sv */
// far-side model: timer counter, update and trigger pulses, channel input pins
`timescale 1ns/1ps
module tcc_far_model (
   output logic [15:0] counter_value,
   output logic count_down,
   output logic update_event,
   output logic trigger_edge,
   output logic internal_trigger_input,
   output logic ch2_in,
   output logic ch3_in,
   input wire logic pclk
);
   initial begin
      {counter_value, count_down, update_event, trigger_edge} = '0;
      {internal_trigger_input, ch2_in, ch3_in} = '0;
   end
   ////////////////////////////////////////////////////////////
   // counter held still so that capture values are known
   task automatic cnt(input logic [15:0] v, input logic d);
      @(posedge pclk);
      counter_value <= v;
      count_down <= d;
   endtask : cnt
   // sel 0 update event, else trigger edge; always one cycle
   task automatic pulse(input int sel);
      @(posedge pclk);
      if (sel == 0) begin
         update_event <= 1'b1;
      end else begin
         trigger_edge <= 1'b1;
      end
      @(posedge pclk);
      {update_event, trigger_edge} <= 2'b00;
   endtask : pulse
   // src 0 ch2 pin, 1 ch3 pin, 2 internal trigger; level kept n cycles
   task automatic hold(input int src, input logic v, input int n);
      @(posedge pclk);
      case (src)
         0: ch2_in <= v;
         1: ch3_in <= v;
         default: internal_trigger_input <= v;
      endcase
      repeat (n - 1) @(posedge pclk);
   endtask : hold
endmodule : tcc_far_model

/* hdl/tcc_ctl.sv */
// capture/compare channel control of a timer: registers, compare output, capture path
`timescale 1ns/1ps
module tcc_ctl (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [15:0] counter_value,
   input wire logic count_down,
   input wire logic update_event,
   input wire logic trigger_edge,
   input wire logic internal_trigger_input,
   input wire logic ch2_in,
   input wire logic ch3_in,
   output logic ch2_output,
   output logic ch2_output_en,
   output logic [1:0] capture_event
);
   import tcc_pkg::*;

   typedef struct packed {
      logic [15:0] mode;
      logic [15:0] chen;
      logic [1:0] protection_level;
      logic [15:0] cv_pre;
      logic [15:0] cv_act;
      logic prep;
      logic pwm_prev;
      logic [2:0] prev_mode;
      logic out;
      logic [4:0] dts_cnt;
      logic [1:0] s1;
      logic [1:0] s2;
      logic [1:0] sel_q;
      logic [1:0][2:0] ecnt;
      logic [1:0][15:0] capv;
      logic [1:0] cap;
      logic [31:0] rdata;
   } tcc_state_t;

   tcc_state_t st;
   tcc_state_t next_st;
   logic [1:0] filt;
   logic setup, acc, wr, mapped;
   logic [15:0] wmode, keep;
   logic [1:0] ms, edge_ev;
   logic [1:0] psc;
   logic sel;
   logic en, pol;
   logic [2:0] mode2;
   logic lt, gt, match, pwm_lvl, fast_lvl, is_pwm, fast_hit;
   logic [31:0] rd;

   ////////////////////////////////////////////////////////////////////////////////
   // input filters; the sample rate comes from each channel's own filter code
   for (genvar g = 0; g < 2; g++) begin : g_flt
      logic [6:0] cfg;
      assign cfg = flt_cfg(st.mode[MODE_UPPER*g + FLT_POS +: 4]);
      tcc_flt u_flt (
         .pclk(pclk),
         .presetn(presetn),
         .sample_tick(samp_tick(cfg[6:4], st.dts_cnt)),
         .din(st.s2[g]),
         .need(cfg[3:0]),
         .dout(filt[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////////
   // zero-wait slave; read data is latched in the setup cycle so prdata is a flop
   assign setup = psel && !penable;
   assign acc = psel && penable;
   assign wr = acc && pwrite;
   assign mapped = (paddr == OFS_MODE) || (paddr == OFS_CHEN) || (paddr == OFS_CV2) ||
                   (paddr == OFS_CV3) || (paddr == OFS_PROTECTION_LEVEL);
   assign pready = 1'b1;
   assign pslverr = acc && !mapped;
   assign prdata = st.rdata;

   always_comb begin
      rd = 32'h0000_0000;
      case (paddr)
         OFS_MODE: rd = {16'h0000, st.mode};
         OFS_CHEN: rd = {16'h0000, st.chen};
         OFS_CV2: rd = {16'h0000, (st.mode[MS_POS +: 2] == MS_OUT) ? st.cv_pre : st.capv[0]};
         OFS_CV3: rd = {16'h0000, st.capv[1]};
         OFS_PROTECTION_LEVEL: begin
            rd[PROTECTION_LEVEL_POS +: 2] = st.protection_level;
            rd[STAT_PREP_POS] = st.prep;
            rd[STAT_FLT_POS +: 2] = filt;
         end
         default: rd = 32'h0000_0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_st = st;
      keep = 16'h0000;
      wmode = 16'h0000;
      ms = 2'h0;
      psc = 2'h0;
      sel = 1'b0;
      en = 1'b0;
      pol = 1'b0;
      edge_ev = 2'h0;
      next_st.s1 = {ch3_in, ch2_in};
      next_st.s2 = st.s1;
      next_st.dts_cnt = 5'(st.dts_cnt + 5'h01);
      next_st.cap = 2'h0;
      if (setup) begin
         next_st.rdata = rd;
      end

      // register writes
      if (wr && paddr == OFS_MODE) begin
         wmode = 16'(lane_merge({16'h0000, st.mode}, pwdata, pstrb));
         for (int i = 0; i < 2; i++) begin
            if (st.chen[CHEN_STRIDE*(i+2) + CHEN_EN_POS]) begin
               keep[MODE_UPPER*i + MS_POS +: 2] = 2'h3;
            end
            if (st.protection_level == PROTECTION_LEVEL_LOCK && st.mode[MODE_UPPER*i + MS_POS +: 2] == MS_OUT) begin
               keep[MODE_UPPER*i + CTL_POS +: 3] = 3'h7;
               keep[MODE_UPPER*i + SEN_POS] = 1'b1;
            end
         end
         next_st.mode = (wmode & ~keep) | (st.mode & keep);
      end
      if (wr && paddr == OFS_CHEN) begin
         next_st.chen = 16'(lane_merge({16'h0000, st.chen}, pwdata, pstrb)) & CHEN_MASK;
      end
      if (wr && paddr == OFS_PROTECTION_LEVEL && pstrb[0]) begin
         next_st.protection_level = pwdata[PROTECTION_LEVEL_POS +: 2];
      end
      if (wr && paddr == OFS_CV2 && st.mode[MS_POS +: 2] == MS_OUT) begin
         next_st.cv_pre = 16'(lane_merge({16'h0000, st.cv_pre}, pwdata, pstrb));
         if (!st.mode[SEN_POS]) begin
            next_st.cv_act = next_st.cv_pre;
         end
      end
      if (update_event && st.mode[SEN_POS]) begin
         next_st.cv_act = next_st.cv_pre;
      end

      // capture path, channel 2 in slot 0 and channel 3 in slot 1
      for (int i = 0; i < 2; i++) begin
         ms = st.mode[MODE_UPPER*i + MS_POS +: 2];
         psc = st.mode[MODE_UPPER*i + PSC_POS +: 2];
         en = st.chen[CHEN_STRIDE*(i+2) + CHEN_EN_POS];
         pol = st.chen[CHEN_STRIDE*(i+2) + CHEN_POL_POS];
         case (ms)
            MS_OWN: sel = filt[i];
            MS_NEIGH: sel = filt[1-i];
            MS_TRIG: sel = internal_trigger_input;
            default: sel = 1'b0;
         endcase
         // raw level kept, so a polarity change alone never looks like an edge
         next_st.sel_q[i] = sel;
         edge_ev[i] = (sel ^ pol) && !(st.sel_q[i] ^ pol) && ms != MS_OUT;
         if (!en) begin
            next_st.ecnt[i] = 3'h0;
         end else if (edge_ev[i]) begin
            if (st.ecnt[i] == psc_last(psc)) begin
               next_st.ecnt[i] = 3'h0;
               next_st.cap[i] = 1'b1;
               next_st.capv[i] = counter_value;
            end else begin
               next_st.ecnt[i] = 3'(st.ecnt[i] + 3'h1);
            end
         end
      end

      // channel 2 compare output
      case (mode2)
         CMP_SET: begin
            if (match) begin
               next_st.prep = 1'b1;
            end
         end
         CMP_CLR: begin
            if (match) begin
               next_st.prep = 1'b0;
            end
         end
         CMP_TOGGLE: begin
            if (match) begin
               next_st.prep = !st.prep;
            end
         end
         CMP_LOW: next_st.prep = 1'b0;
         CMP_HIGH: next_st.prep = 1'b1;
         CMP_PWM0, CMP_PWM1: begin
            if (fast_hit) begin
               next_st.prep = fast_lvl;
            end else if (st.prev_mode == CMP_TIMING || pwm_lvl != st.pwm_prev) begin
               next_st.prep = pwm_lvl;
            end
         end
         default: next_st.prep = st.prep;
      endcase
      next_st.prev_mode = mode2;
      next_st.pwm_prev = pwm_lvl;
      // inactive level equals the polarity bit, so a disabled pin idles inactive
      if (st.chen[CHEN_STRIDE*2 + CHEN_EN_POS] && st.mode[MS_POS +: 2] == MS_OUT) begin
         next_st.out = next_st.prep ^ st.chen[CHEN_STRIDE*2 + CHEN_POL_POS];
      end else begin
         next_st.out = st.chen[CHEN_STRIDE*2 + CHEN_POL_POS];
      end
   end

   assign mode2 = st.mode[CTL_POS +: 3];
   assign lt = counter_value < st.cv_act;
   assign gt = counter_value > st.cv_act;
   assign match = counter_value == st.cv_act;
   assign is_pwm = mode2 == CMP_PWM0 || mode2 == CMP_PWM1;
   // PWM1: up low below, down high above; PWM0 is its inverse sense
   assign pwm_lvl = mode2[0] ? (count_down ? gt : !lt) : (count_down ? !gt : lt);
   assign fast_lvl = mode2[0] ? !count_down : count_down;
   assign fast_hit = is_pwm && st.mode[FEN_POS] && trigger_edge;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
         st.mode <= RST_MODE;
         st.chen <= RST_CHEN;
         st.protection_level <= RST_PROTECTION_LEVEL;
         st.cv_pre <= RST_CV;
         st.cv_act <= RST_CV;
      end else begin
         st <= next_st;
      end
   end

   assign ch2_output = st.out;
   assign ch2_output_en = st.chen[CHEN_STRIDE*2 + CHEN_EN_POS] && st.mode[MS_POS +: 2] == MS_OUT;
   assign capture_event = st.cap;

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_pwm1_up;
      (mode2 == CMP_PWM1 && !count_down && lt && st.pwm_prev && !fast_hit) |=> !st.prep;
   endproperty
   a_pwm1_up: assert property (p_pwm1_up) else $error("pwm1 up below did not go low");

   property p_pwm1_down;
      (mode2 == CMP_PWM1 && count_down && gt && !st.pwm_prev && !fast_hit) |=> st.prep;
   endproperty
   a_pwm1_down: assert property (p_pwm1_down) else $error("pwm1 down above not high");

   property p_pwm0_up;
      (mode2 == CMP_PWM0 && !count_down && lt && !st.pwm_prev && !fast_hit) |=> st.prep;
   endproperty
   a_pwm0_up: assert property (p_pwm0_up) else $error("pwm0 up below did not go high");

   property p_pwm_hold;
      (is_pwm && st.prev_mode != CMP_TIMING && pwm_lvl == st.pwm_prev && !fast_hit)
         |=> $stable(st.prep);
   endproperty
   a_pwm_hold: assert property (p_pwm_hold) else $error("pwm level moved without cause");

   property p_lock;
      (wr && paddr == OFS_MODE && st.protection_level == PROTECTION_LEVEL_LOCK && st.mode[MS_POS +: 2] == MS_OUT)
         |=> $stable(st.mode[CTL_POS +: 3]) && $stable(st.mode[SEN_POS]);
   endproperty
   a_lock: assert property (p_lock) else $error("locked compare control changed");

   property p_shadow;
      (st.mode[SEN_POS] && !update_event) |=> $stable(st.cv_act);
   endproperty
   a_shadow: assert property (p_shadow) else $error("shadowed value changed early");

   property p_fast;
      (fast_hit && mode2 == CMP_PWM1 && !count_down) |=> st.prep;
   endproperty
   a_fast: assert property (p_fast) else $error("fast trigger did not act as match");

   property p_ms_wr;
      (wr && paddr == OFS_MODE && st.chen[CHEN_STRIDE*2 + CHEN_EN_POS])
         |=> $stable(st.mode[MS_POS +: 2]);
   endproperty
   a_ms_wr: assert property (p_ms_wr) else $error("mode select written while enabled");

   property p_psc;
      (edge_ev[0] && st.chen[CHEN_STRIDE*2 + CHEN_EN_POS] &&
       st.ecnt[0] != psc_last(st.mode[PSC_POS +: 2])) |=> !st.cap[0];
   endproperty
   a_psc: assert property (p_psc) else $error("capture before edge count reached");

   property p_psc_clr;
      !st.chen[CHEN_STRIDE*3 + CHEN_EN_POS] |=> (st.ecnt[1] == 3'h0) && !st.cap[1];
   endproperty
   a_psc_clr: assert property (p_psc_clr) else $error("edge count kept while disabled");

   property p_out;
      (st.chen[CHEN_STRIDE*2 + CHEN_EN_POS] && st.mode[MS_POS +: 2] == MS_OUT)
         ##1 $stable(st.chen) |-> ch2_output == (st.prep ^ st.chen[CHEN_STRIDE*2 + CHEN_POL_POS]);
   endproperty
   a_out: assert property (p_out) else $error("output polarity wrong");

endmodule : tcc_ctl

/* hdl/tcc_flt.sv */
// digital input filter: accepts a level after a run of equal samples
`timescale 1ns/1ps
module tcc_flt (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic sample_tick,
   input wire logic din,
   input wire logic [3:0] need,
   output logic dout
);
   import tcc_pkg::*;

   typedef struct packed {
      logic last;
      logic [3:0] cnt;
      logic dout;
   } tcc_flt_state_t;

   tcc_flt_state_t st;
   tcc_flt_state_t next_st;
   logic [3:0] run;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_st = st;
      run = 4'h0;
      if (need == 4'h0) begin
         next_st.dout = din;
         next_st.last = din;
         next_st.cnt = 4'h0;
      end else if (sample_tick) begin
         if (din != st.last) begin
            run = 4'h1;
         end else if (st.cnt < need) begin
            run = 4'(st.cnt + 4'h1);
         end else begin
            run = st.cnt;
         end
         next_st.last = din;
         next_st.cnt = run;
         if (run >= need) begin
            next_st.dout = din;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign dout = st.dout;

   ////////////////////////////////////////////////////////////////////////////////
   property p_flt_bypass;
      @(posedge pclk) disable iff (!presetn)
      (need == 4'h0) |=> (dout == $past(din));
   endproperty
   a_flt_bypass: assert property (p_flt_bypass) else $error("filter bypass lost input");

endmodule : tcc_flt

/* pkg/tcc_pkg.sv */
// constants, field layout and decode functions of the timer channel control block
// Operation
// - PWM mode 1: up low below, down high above
// - PWM mode 0: up high below, down low above
// - PWM level changes on timing exit or comparison
// - compare control locked at protection 11, output mode
// - shadow enable loads compare value at update
// - fast enable: trigger edge acts as compare match
// - mode select: output, own, neighbour, internal trigger
// - mode select writable only while channel disabled
// - filter counts equal samples, code 0000 bypasses
// - filter code maps sampling rate and sample count
// - prescaler captures every 1, 2, 4, 8 edges
// - prescaler edge count cleared while channel disabled
// - output polarity 0 active high, 1 active low
// - input polarity selects rising or inverted falling edge
// - enable gates active output or capture events
// - enable and polarity at bits 4n and 4n+1
// - input layout: filter, prescaler, mode per channel byte
// - enable register accepts byte, half-word and word writes
package tcc_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   localparam logic [11:0] OFS_MODE = 12'h01C;
   localparam logic [11:0] OFS_CHEN = 12'h020;
   localparam logic [11:0] OFS_CV2 = 12'h03C;
   localparam logic [11:0] OFS_CV3 = 12'h040;
   localparam logic [11:0] OFS_PROTECTION_LEVEL = 12'h044;

   localparam logic [15:0] RST_MODE = 16'h0000;
   localparam logic [15:0] RST_CHEN = 16'h0000;
   localparam logic [15:0] RST_CV = 16'h0000;
   localparam logic [1:0] RST_PROTECTION_LEVEL = 2'h0;

   // enable register: channel n at 4n, polarity one above
   localparam int CHEN_STRIDE = 4;
   localparam int CHEN_EN_POS = 0;
   localparam int CHEN_POL_POS = 1;
   localparam logic [15:0] CHEN_MASK = 16'h3333;

   // mode register: channel 2 in byte 0, channel 3 in byte 1
   localparam int MODE_UPPER = 8;
   localparam int MS_POS = 0;
   localparam int FEN_POS = 2;
   localparam int SEN_POS = 3;
   localparam int CTL_POS = 4;
   localparam int PSC_POS = 2;
   localparam int FLT_POS = 4;

   localparam int PROTECTION_LEVEL_POS = 0;
   localparam int STAT_PREP_POS = 8;
   localparam int STAT_FLT_POS = 9;

   localparam logic [2:0] CMP_TIMING = 3'h0;
   localparam logic [2:0] CMP_SET = 3'h1;
   localparam logic [2:0] CMP_CLR = 3'h2;
   localparam logic [2:0] CMP_TOGGLE = 3'h3;
   localparam logic [2:0] CMP_LOW = 3'h4;
   localparam logic [2:0] CMP_HIGH = 3'h5;
   localparam logic [2:0] CMP_PWM0 = 3'h6;
   localparam logic [2:0] CMP_PWM1 = 3'h7;

   localparam logic [1:0] MS_OUT = 2'h0;
   localparam logic [1:0] MS_OWN = 2'h1;
   localparam logic [1:0] MS_NEIGH = 2'h2;
   localparam logic [1:0] MS_TRIG = 2'h3;
   localparam logic [1:0] PROTECTION_LEVEL_LOCK = 2'h3;

   localparam int DTS_CNT_W = 5;

   ////////////////////////////////////////////////////////////////////////////////
   // filter code to {rate, samples}; rate 0 is the timer clock, k is dead-time clock / 2^k
   function automatic logic [6:0] flt_cfg(input logic [3:0] code);
      case (code)
         4'h0: return {3'h0, 4'h0};
         4'h1: return {3'h0, 4'h2};
         4'h2: return {3'h0, 4'h4};
         4'h3: return {3'h0, 4'h8};
         4'h4: return {3'h1, 4'h6};
         4'h5: return {3'h1, 4'h8};
         4'h6: return {3'h2, 4'h6};
         4'h7: return {3'h2, 4'h8};
         4'h8: return {3'h3, 4'h6};
         4'h9: return {3'h3, 4'h8};
         4'hA: return {3'h4, 4'h5};
         4'hB: return {3'h4, 4'h6};
         4'hC: return {3'h4, 4'h8};
         4'hD: return {3'h5, 4'h5};
         4'hE: return {3'h5, 4'h6};
         default: return {3'h5, 4'h8};
      endcase
   endfunction : flt_cfg

   function automatic logic samp_tick(input logic [2:0] rate, input logic [4:0] cnt);
      logic [4:0] m;
      m = 5'((6'h01 << rate) - 6'h01);
      return (cnt & m) == m;
   endfunction : samp_tick

   // last edge count before a capture: 0, 1, 3 or 7
   function automatic logic [2:0] psc_last(input logic [1:0] psc);
      return 3'((4'h1 << psc) - 4'h1);
   endfunction : psc_last

   function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return r;
   endfunction : lane_merge

endpackage : tcc_pkg
